// file: src/ccp_pkg.sv
// constants and types for the capture/compare/pwm channel
package ccp_pkg;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_DUTY_LOW = 8'h04;
  localparam logic [7:0] OFS_DUTY_BUF = 8'h08;
  localparam logic [7:0] OFS_TSEL = 8'h0C;
  localparam logic [7:0] OFS_PERIOD = 8'h10;
  localparam logic [7:0] OFS_TCTRL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam int MODE_LSB = 0;
  localparam int FRAC_LSB = 4;
  localparam int TON_BIT = 2;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLEAR = 4'h9;
  localparam logic [3:0] MODE_SWINT = 4'hA;
  localparam logic [3:0] MODE_TRIG = 4'hB;
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  typedef struct packed {
    logic [15:0] pair_a;
    logic [15:0] pair_b;
    logic step_a;
    logic step_b;
  } compare_timers_t;
endpackage : ccp_pkg

// file: src/ccp_compare_pwm_unit.sv
// one capture/compare/pwm channel with apb registers
//
// Notes on behaviour
// - compare match flagged when timer steps off the equal value
// - pwm output offers up to ten bits of duty resolution
// - writing zero to control forces channel latch low only
// - eight-bit period register sets pwm period
// - step after timer equals period: clear timer, set pin if the new duty is nonzero, reload duty
// - timer postscaler never affects pwm period
// - duty is low register msbs plus control bits five and four
// - duty fields reach active buffer only at period end
// - duty buffer register read-only in pwm mode
// - duty double-buffered in buffer register plus hidden two bits
// - pin cleared when duty equals timer with two low bits
// - duty beyond period keeps pin high whole period
// - high time is duty times clock times prescale; here one quarter of that, as the timer steps every clock
// - prescaler divides by 1, 4 or 16
// - resolution equals log2 of clock over pwm rate
// - compare match sets flag and drives pin per mode
// - mode 1010 flags only, pin untouched
// - mode 1011 emits trigger resetting the compare timer pair
// - select bit picks timer pair one/two or three/four
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/10ps
module ccp_compare_pwm_unit
  import ccp_pkg::*;
#(
  parameter int PRE_BITS = 4
)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire compare_timers_t TIMERS,
  input wire logic PORT_LATCH,
  input wire logic PORT_DIR_IN,
  output logic PIN_OUT,
  output logic PIN_OE,
  output logic MATCH_FLAG,
  output logic TRIGGER_A,
  output logic TRIGGER_B,
  output logic POSTSCALE_EVENT
);
  logic [7:0] control;
  logic [7:0] duty_low;
  logic [7:0] duty_buf;
  logic [1:0] frac_buf;
  logic tsel;
  logic [7:0] period;
  logic [6:0] tctrl;
  logic [7:0] timer;
  logic [PRE_BITS-1:0] pre_cnt;
  logic [3:0] post_cnt;
  logic chan_latch;
  logic flag;
  logic [15:0] cmp_prev;
  logic [15:0] cmp_pair;
  logic cmp_step;
  logic was_equal;
  logic wr;
  logic rd;
  logic pwm_mode;
  logic cmp_mode;
  logic tick;
  logic period_end;
  logic [1:0] fine;
  logic fine_step;
  logic [9:0] base_next;
  logic [9:0] duty_active;
  logic match_evt;
  logic flag_clr;

  function automatic logic hit(input logic [7:0] a);
    hit = (PADDR == a);
  endfunction : hit

  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  assign pwm_mode = (control[3:2] == 2'b11);
  assign cmp_mode = (control[3] && !pwm_mode) || control[3:0] == MODE_TOGGLE;

  // unmapped addresses answer with an error, registers stay intact
  assign PSLVERR = PSEL && PENABLE && !(hit(OFS_CONTROL) ||
    hit(OFS_DUTY_LOW) || hit(OFS_DUTY_BUF) || hit(OFS_TSEL) ||
    hit(OFS_PERIOD) || hit(OFS_TCTRL) || hit(OFS_STATUS));

  always_ff @(posedge CLK)
  begin
    if (RESET)
      control <= RST_CONTROL;
    else if (wr && hit(OFS_CONTROL))
      control <= {2'b00, PWDATA[5:0]};
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      duty_low <= 8'h00;
      tsel <= 1'b0;
      period <= RST_PERIOD;
      tctrl <= 7'h00;
    end
    else if (wr)
    begin
      if (hit(OFS_DUTY_LOW))
        duty_low <= PWDATA[7:0];
      if (hit(OFS_TSEL))
        tsel <= PWDATA[0];
      if (hit(OFS_PERIOD))
        period <= PWDATA[7:0];
      if (hit(OFS_TCTRL))
        tctrl <= PWDATA[6:0];
    end
  end

  // period timer prescaler: 1, 4 or 16
  always_ff @(posedge CLK)
  begin
    if (RESET || !tctrl[TON_BIT])
      pre_cnt <= '0;
    else
      pre_cnt <= pre_cnt + 1'b1;
  end

  always_comb
  begin
    case (tctrl[1:0])
      PRE_DIV1: tick = tctrl[TON_BIT];
      PRE_DIV4: tick = tctrl[TON_BIT] && (pre_cnt[1:0] == 2'h3);
      default: tick = tctrl[TON_BIT] && (pre_cnt[3:0] == 4'hF);
    endcase
  end

  // fine bits from the prescaler, or fixed at 3 at divide 1
  always_comb
  begin
    case (tctrl[1:0])
      PRE_DIV1: fine = 2'h3;
      PRE_DIV4: fine = pre_cnt[1:0];
      default: fine = pre_cnt[3:2];
    endcase
  end

  // time base one fine step ahead
  // registered latch must fall as the base reaches the duty, not a step later
  // div-1 keeps fine bits at 3, so reaching or passing the duty counts
  assign fine_step = tctrl[TON_BIT] && (tctrl[1:0] == PRE_DIV1 ||
    tctrl[1:0] == PRE_DIV4 || pre_cnt[1:0] == 2'h3);
  assign base_next = (tctrl[1:0] == PRE_DIV1) ? {timer + 8'h01, 2'h3} :
    {timer, fine} + 10'h001;

  // timer clears on the step after equalling the period
  assign period_end = tick && (timer == period);

  always_ff @(posedge CLK)
  begin
    if (RESET)
      timer <= 8'h00;
    else if (period_end)
      timer <= 8'h00;
    else if (tick)
      timer <= timer + 8'h01;
  end

  // postscaler only gates a separate event, never the period
  always_ff @(posedge CLK)
  begin
    if (RESET || !tctrl[TON_BIT])
      post_cnt <= 4'h0;
    else if (period_end)
      post_cnt <= (post_cnt == tctrl[6:3]) ? 4'h0 : post_cnt + 4'h1;
  end
  assign POSTSCALE_EVENT = period_end && (post_cnt == tctrl[6:3]);

  // double buffer loads only at period end
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      duty_buf <= 8'h00;
      frac_buf <= 2'h0;
    end
    else if (pwm_mode && period_end)
    begin
      duty_buf <= duty_low;
      frac_buf <= control[FRAC_LSB+1:FRAC_LSB];
    end
    // buffer writable only outside pwm mode
    else if (!pwm_mode && wr && hit(OFS_DUTY_BUF))
      duty_buf <= PWDATA[7:0];
  end
  assign duty_active = {duty_buf, frac_buf};

  assign cmp_pair = tsel ? TIMERS.pair_b : TIMERS.pair_a;
  assign cmp_step = tsel ? TIMERS.step_b : TIMERS.step_a;

  // match fires as the timer leaves the equal value
  always_ff @(posedge CLK)
  begin
    if (RESET)
      was_equal <= 1'b0;
    else if (cmp_step)
      was_equal <= 1'b0;
    else
      was_equal <= (cmp_pair == {duty_buf, duty_low});
  end
  assign cmp_prev = {duty_buf, duty_low};
  assign match_evt = cmp_mode && cmp_step &&
    (was_equal || cmp_pair == cmp_prev);

  // special event trigger resets the assigned pair
  assign TRIGGER_A = match_evt && (control[3:0] == MODE_TRIG) && !tsel;
  assign TRIGGER_B = match_evt && (control[3:0] == MODE_TRIG) && tsel;

  always_ff @(posedge CLK)
  begin
    if (RESET)
      chan_latch <= 1'b0;
    else if (wr && hit(OFS_CONTROL) && PWDATA[7:0] == 8'h00)
      chan_latch <= 1'b0;
    else if (wr && hit(OFS_CONTROL) && PWDATA[3:0] == MODE_SET)
      chan_latch <= 1'b0;
    else if (wr && hit(OFS_CONTROL) && PWDATA[3:0] == MODE_CLEAR)
      chan_latch <= 1'b1;
    else if (pwm_mode)
    begin
      if (period_end)
        chan_latch <= ({duty_low, control[5:4]} != 10'h000);
      else if (fine_step && base_next >= duty_active)
        chan_latch <= 1'b0;
    end
    else if (match_evt)
    begin
      case (control[3:0])
        MODE_TOGGLE: chan_latch <= !chan_latch;
        MODE_SET: chan_latch <= 1'b1;
        MODE_CLEAR: chan_latch <= 1'b0;
        default: chan_latch <= chan_latch;
      endcase
    end
  end

  // flag: set wins over a software clear in the same cycle
  assign flag_clr = wr && hit(OFS_STATUS) && PWDATA[0];
  always_ff @(posedge CLK)
  begin
    if (RESET)
      flag <= 1'b0;
    else if (match_evt)
      flag <= 1'b1;
    else if (flag_clr)
      flag <= 1'b0;
  end
  assign MATCH_FLAG = flag;

  // pin follows port latch unless an output mode drives it
  always_comb
  begin
    if (pwm_mode || (cmp_mode && control[3:0] != MODE_SWINT &&
        control[3:0] != MODE_TRIG) || control[3:0] == MODE_TOGGLE)
      PIN_OUT = chan_latch;
    else
      PIN_OUT = PORT_LATCH;
    PIN_OE = !PORT_DIR_IN;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      PRDATA <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE)
    begin
      case (PADDR)
        OFS_CONTROL: PRDATA <= {24'h0, control};
        OFS_DUTY_LOW: PRDATA <= {24'h0, duty_low};
        OFS_DUTY_BUF: PRDATA <= {24'h0, duty_buf};
        OFS_TSEL: PRDATA <= {31'h0, tsel};
        OFS_PERIOD: PRDATA <= {24'h0, period};
        OFS_TCTRL: PRDATA <= {25'h0, tctrl};
        OFS_STATUS: PRDATA <= {22'h0, timer, chan_latch, flag};
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  sequence period_hit_s;
    pwm_mode && period_end;
  endsequence

  timer_clear_a: assert property (@(posedge CLK) disable iff (RESET)
    period_hit_s |=> timer == 8'h00)
    else $error("timer not cleared at period end");
  duty_reload_a: assert property (@(posedge CLK) disable iff (RESET)
    period_hit_s |=> duty_buf == $past(duty_low))
    else $error("duty buffer not reloaded");
  buffer_hold_a: assert property (@(posedge CLK) disable iff (RESET)
    pwm_mode && !period_end && $past(pwm_mode) |=> $stable(duty_buf))
    else $error("duty buffer changed mid period");
  zero_ctrl_a: assert property (@(posedge CLK) disable iff (RESET)
    wr && hit(OFS_CONTROL) && PWDATA[7:0] == 8'h00 |=> !chan_latch)
    else $error("latch not low after zero control");
  match_flag_a: assert property (@(posedge CLK) disable iff (RESET)
    match_evt |=> flag)
    else $error("flag not set on match");
  trig_mode_a: assert property (@(posedge CLK) disable iff (RESET)
    (TRIGGER_A || TRIGGER_B) |-> control[3:0] == MODE_TRIG)
    else $error("trigger outside trigger mode");
  swint_pin_a: assert property (@(posedge CLK) disable iff (RESET)
    control[3:0] == MODE_SWINT |-> PIN_OUT == PORT_LATCH)
    else $error("pin driven in software interrupt mode");
  step_only_a: assert property (@(posedge CLK) disable iff (RESET)
    match_evt |-> cmp_step)
    else $error("match without timer step");
  long_duty_a: assert property (@(posedge CLK) disable iff (RESET)
    period_hit_s ##1 (pwm_mode && duty_active > {period, 2'h3} &&
      !period_end)[*2] |-> chan_latch)
    else $error("pin cleared with duty beyond period");

  sequence duty_reached_s;
    pwm_mode && !period_end && fine_step && base_next >= duty_active &&
      !(wr && hit(OFS_CONTROL));
  endsequence

  pin_clear_a: assert property (@(posedge CLK) disable iff (RESET)
    duty_reached_s |=> !chan_latch)
    else $error("pin not cleared at duty match");
  toggle_match_a: assert property (@(posedge CLK) disable iff (RESET)
    match_evt && control[3:0] == MODE_TOGGLE && !(wr && hit(OFS_CONTROL))
      |=> chan_latch != $past(chan_latch))
    else $error("latch not toggled on match");
endmodule : ccp_compare_pwm_unit

// file: sim/pin_load.sv
// external load on the channel pin, measures high time and period
`timescale 1ns/10ps
module pin_load
(
  input wire logic clk,
  input wire logic pin,
  input wire logic oe,
  output logic [15:0] hi_len,
  output logic [15:0] per_len
);
  logic lvl;
  logic prev = 1'h0;
  logic [15:0] hi = 16'h0;
  logic [15:0] per = 16'h0;
  // undriven pin sits at the pull-down
  assign lvl = oe ? pin : 1'h0;
  always_ff @(posedge clk)
  begin
    prev <= lvl;
    if (lvl && !prev)
    begin
      hi_len <= hi;
      per_len <= per;
      hi <= 16'h1;
      per <= 16'h1;
    end
    else
    begin
      hi <= hi + {15'h0, lvl};
      per <= per + 16'h1;
    end
  end
endmodule : pin_load

// file: sim/ccp_compare_pwm_unit_tb.sv
// self-checking bench for the compare/pwm channel
`timescale 1ns/10ps
module ccp_compare_pwm_unit_tb;
  import ccp_pkg::*;
  logic CLK = 1'h0;
  logic RESET = 1'h1;
  logic PSEL = 1'h0;
  logic PENABLE = 1'h0;
  logic PWRITE = 1'h0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA, rd;
  logic PREADY, PSLVERR, PIN_OUT, PIN_OE, err, trig;
  logic PORT_LATCH = 1'h0;
  logic PORT_DIR_IN = 1'h1;
  logic MATCH_FLAG, TRIGGER_A, TRIGGER_B, POSTSCALE_EVENT;
  compare_timers_t tm = '0;
  logic [15:0] hi_len, per_len, v;
  logic [7:0] w;
  int n_fail = 0;
  int num_checks = 0;
  int k;

  initial forever #20 CLK = ~CLK;

  ccp_compare_pwm_unit i_dut (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TIMERS(tm),
    .PORT_LATCH(PORT_LATCH), .PORT_DIR_IN(PORT_DIR_IN), .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE), .MATCH_FLAG(MATCH_FLAG), .TRIGGER_A(TRIGGER_A),
    .TRIGGER_B(TRIGGER_B), .POSTSCALE_EVENT(POSTSCALE_EVENT));
  pin_load i_load (.clk(CLK), .pin(PIN_OUT), .oe(PIN_OE), .hi_len(hi_len),
    .per_len(per_len));

  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge CLK);
    PSEL <= 1'h1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'h1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge CLK);
      if (PREADY === 1'h1)
        break;
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    if (i == 16)
    begin
      chk("pready", 32'h0, 32'h1);
      end_of_test;
    end
  endtask : xfer

  task hold(input logic lvl);
    int e;
    k = 0;
    e = 0;
    repeat (40) @(negedge CLK)
    begin
      k += int'(PIN_OUT === lvl);
      e += int'(POSTSCALE_EVENT === 1'h1);
    end
    chk("steady level", k, 32'h28);
    // postscale 1 at a four-cycle period gives ten events
    chk("postscale events", e, 32'hA);
  endtask : hold

  // one compare match on a random value and a random timer pair
  task cmp(input logic [3:0] m, input logic lat);
    logic s;
    s = 1'($urandom);
    v = 16'($urandom);
    xfer(1'h1, OFS_CONTROL, 32'h0);
    xfer(1'h1, OFS_TSEL, {31'h0, s});
    xfer(1'h1, OFS_DUTY_LOW, {24'h0, v[7:0]});
    xfer(1'h1, OFS_DUTY_BUF, {24'h0, v[15:8]});
    tm <= s ? compare_timers_t'{~v, v, 1'h0, 1'h0} :
      compare_timers_t'{v, ~v, 1'h0, 1'h0};
    xfer(1'h1, OFS_CONTROL, {28'h0, m});
    xfer(1'h1, OFS_STATUS, 32'h1);
    xfer(1'h0, OFS_STATUS, 32'h0);
    chk("flag while equal", rd[0], 32'h0);
    @(posedge CLK);
    tm.step_a <= !s;
    tm.step_b <= s;
    @(negedge CLK) trig = s ? TRIGGER_B : TRIGGER_A;
    @(posedge CLK);
    tm <= '{tm.pair_a + 16'h1, tm.pair_b + 16'h1, 1'h0, 1'h0};
    repeat (4) @(negedge CLK) trig |= s ? TRIGGER_B : TRIGGER_A;
    xfer(1'h0, OFS_STATUS, 32'h0);
    chk("flag after step", rd[0], 32'h1);
    chk("flag output", MATCH_FLAG, 32'h1);
    chk("pin enable", PIN_OE, 32'h1);
    if (m != MODE_TRIG)
      chk("latch", rd[1], lat);
    if (m == MODE_SWINT)
      chk("pin", PIN_OUT, PORT_LATCH);
    else if (m != MODE_TRIG)
      chk("pin level", PIN_OUT, lat);
    chk("trigger", trig, m == MODE_TRIG);
  endtask : cmp

  initial
  begin
    void'($urandom(80));
    repeat (8) @(posedge CLK);
    RESET <= 1'h0;
    xfer(1'h0, OFS_CONTROL, 32'h0);
    chk("control reset", rd, RST_CONTROL);
    xfer(1'h0, OFS_PERIOD, 32'h0);
    chk("period reset", rd, RST_PERIOD);
    xfer(1'h0, 8'h1C, 32'h0);
    chk("unmapped", err, 32'h1);
    PORT_LATCH <= 1'($urandom);
    // pin made an output before use
    PORT_DIR_IN <= 1'h0;
    cmp(MODE_SET, 1'h1);
    cmp(MODE_CLEAR, 1'h0);
    cmp(MODE_TOGGLE, 1'h1);
    cmp(MODE_SWINT, 1'h0);
    cmp(MODE_TRIG, 1'h0);
    xfer(1'h1, OFS_TSEL, 32'h0);
    xfer(1'h1, OFS_PERIOD, 32'h3);
    xfer(1'h1, OFS_DUTY_LOW, 32'h2);
    xfer(1'h1, OFS_TCTRL, 32'h7C);
    xfer(1'h1, OFS_CONTROL, 32'h3C);
    repeat (20) @(posedge CLK);
    chk("high div1", hi_len, 32'h2);
    chk("period div1", per_len, 32'h4);
    xfer(1'h1, OFS_TCTRL, 32'h7D);
    repeat (60) @(posedge CLK);
    chk("high div4", hi_len, 32'hB);
    chk("period div4", per_len, 32'h10);
    xfer(1'h1, OFS_TCTRL, 32'h7E);
    repeat (200) @(posedge CLK);
    chk("high div16", hi_len, 32'h2C);
    chk("period div16", per_len, 32'h40);
    xfer(1'h1, OFS_TCTRL, 32'h04);
    xfer(1'h1, OFS_DUTY_LOW, 32'hFF);
    repeat (10) @(posedge CLK);
    hold(1'h1);
    xfer(1'h1, OFS_CONTROL, 32'h0);
    xfer(1'h0, OFS_STATUS, 32'h0);
    chk("latch cleared", rd[1], 32'h0);
    xfer(1'h1, OFS_DUTY_LOW, 32'h0);
    xfer(1'h1, OFS_CONTROL, 32'h0C);
    repeat (10) @(posedge CLK);
    hold(1'h0);
    xfer(1'h1, OFS_PERIOD, 32'hFF);
    repeat (10) @(posedge CLK);
    w = 8'($urandom) | 8'h01;
    xfer(1'h1, OFS_DUTY_LOW, {24'h0, w});
    xfer(1'h0, OFS_DUTY_BUF, 32'h0);
    chk("buffer before end", rd, 32'h0);
    xfer(1'h1, OFS_DUTY_BUF, {24'h0, ~w});
    xfer(1'h0, OFS_DUTY_BUF, 32'h0);
    chk("buffer read-only", rd, 32'h0);
    repeat (300) @(posedge CLK);
    xfer(1'h0, OFS_DUTY_BUF, 32'h0);
    chk("buffer reloaded", rd, {24'h0, w});
    end_of_test;
  end
endmodule : ccp_compare_pwm_unit_tb
